//--- rtl/itb_map.svh
`ifndef ITB_MAP_SVH
`define ITB_MAP_SVH

// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define ITB_ADDR_MODE 5'h00
`define ITB_ADDR_COUNT 5'h04
`define ITB_ADDR_STATUS 5'h08
`define ITB_ADDR_MASK 5'h0C

// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define ITB_MODE_RSVD_BIT 4
`define ITB_INSEL_CLR_BIT 2
`define ITB_OVF_BIT 0
`define ITB_MODE_RESET 8'h00
`define ITB_CNT_RESET 8'h00
`define ITB_CNT_MAX 8'hFF
`define ITB_STAT_RESET 1'h0
`define ITB_MASK_RESET 1'h0

// ---------------------------------------------------------------
// prescaler taps as log2 of the divide ratio; clock out bits are one below log2 of theirs
// ---------------------------------------------------------------
`define ITB_TAP_S0 13
`define ITB_TAP_S1 12
`define ITB_TAP_S2 11
`define ITB_TAP_S3 9
`define ITB_TAP_S4 8
`define ITB_TAP_S5 7
`define ITB_TAP_S6 5
`define ITB_TAP_S7 3
`define ITB_TAP_W0 7
`define ITB_TAP_W1 6
`define ITB_TAP_W2 5
`define ITB_TAP_W3 2
`define ITB_OUT_BIT_32 4
`define ITB_OUT_BIT_16 3
`define ITB_OUT_BIT_8 2
`define ITB_OUT_BIT_4 1

`endif

//--- rtl/itb_pkg.sv
package itb_pkg;

    typedef struct packed {
        logic [2:0] clkout_select;
        logic reserved;
        logic mode_select;
        logic [2:0] input_select;
    } itb_mode_type;

endpackage : itb_pkg

//--- rtl/itb_prescaler.sv
`timescale 1ns/1ns
module itb_prescaler #(
    parameter int WIDTH = 13
) (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_ce,
    input wire logic i_inc,
    input wire logic i_clr,
    output logic [WIDTH-1:0] o_count
);

    logic [WIDTH-1:0] cnt_d;

    if (WIDTH < 2) begin : g_bad_width
        $error("itb_prescaler: WIDTH must be at least 2");
    end

    // clear wins over increment
    always_comb begin
        cnt_d = o_count;
        if (i_clr) begin
            cnt_d = '0;
        end else if (i_inc) begin
            cnt_d = WIDTH'(o_count + 1'b1);
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_count <= '0;
        end else if (i_ce) begin
            o_count <= cnt_d;
        end
    end

endmodule : itb_prescaler

//--- rtl/itb_timer.sv
// Design decisions made here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "itb_map.svh"

module itb_timer
    import itb_pkg::*;
#(
    parameter int PS_WIDTH = 13,
    parameter int PW_WIDTH = 7
) (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_ce,
    input wire logic i_subclk,
    input wire logic i_subactive,
    input wire logic i_pin_out_en,
    input wire logic [4:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output logic o_irq,
    output logic o_clkout,
    output logic o_clkout_oe
);

    // ---------------------------------------------------------------
    // elaboration checks
    // ---------------------------------------------------------------
    if (PS_WIDTH < `ITB_TAP_S0 || PS_WIDTH > 16) begin : g_bad_ps
        $error("itb_timer: PS_WIDTH must be 13 to 16");
    end
    if (PW_WIDTH < `ITB_TAP_W0 || PW_WIDTH > 16) begin : g_bad_pw
        $error("itb_timer: PW_WIDTH must be 7 to 16");
    end

    // ---------------------------------------------------------------
    // functions
    // ---------------------------------------------------------------
    // true when the low k bits of a prescaler are all ones
    function automatic logic tap_hit(input logic [15:0] cnt,
                                     input int unsigned k);
        logic [15:0] m;
        m = 16'((17'h0_0001 << k) - 17'h0_0001);
        return &(cnt | ~m);
    endfunction : tap_hit

    // divided clock bit index for a /32, /16, /8, /4 code
    function automatic int unsigned out_bit(input logic [1:0] code);
        int unsigned b;
        b = `ITB_OUT_BIT_32;
        case (code)
            2'h0: b = `ITB_OUT_BIT_32;
            2'h1: b = `ITB_OUT_BIT_16;
            2'h2: b = `ITB_OUT_BIT_8;
            2'h3: b = `ITB_OUT_BIT_4;
            default: b = `ITB_OUT_BIT_32;
        endcase
        return b;
    endfunction : out_bit

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    itb_mode_type mode_q, mode_d;
    logic [7:0] cnt_q, cnt_d;
    logic ovf_q, ovf_d;
    logic ien_q, ien_d;
    logic sub_q, sub_d;
    logic wait_q, wait_d;
    logic [31:0] rdata_q, rdata_d;
    logic irq_q, irq_d;
    logic clkout_q, clkout_d;
    logic oe_q, oe_d;

    logic [PS_WIDTH-1:0] ps_cnt;
    logic [PW_WIDTH-1:0] pw_cnt;
    logic [15:0] ps_ext, pw_ext;
    logic ps_inc, pw_inc, pw_clr, cnt_clr;
    logic tick, req, take_wr, wr_lane;
    int unsigned k;

    assign ps_ext = 16'(ps_cnt);
    assign pw_ext = 16'(pw_cnt);

    // ---------------------------------------------------------------
    // prescalers
    // ---------------------------------------------------------------
    // system prescaler stops with the system clock in subactive
    assign ps_inc = !i_subactive;
    assign pw_inc = i_subclk && !sub_q;
    assign cnt_clr = mode_q.mode_select &&
                     mode_q.input_select[`ITB_INSEL_CLR_BIT];
    assign pw_clr = cnt_clr;

    itb_prescaler #(
        .WIDTH(PS_WIDTH)
    ) u_sys_prescaler (
        .i_clk_sys(i_clk_sys),
        .i_arst_n(i_arst_n),
        .i_ce(i_ce),
        .i_inc(ps_inc),
        .i_clr(1'b0),
        .o_count(ps_cnt)
    );

    itb_prescaler #(
        .WIDTH(PW_WIDTH)
    ) u_subclock_prescaler (
        .i_clk_sys(i_clk_sys),
        .i_arst_n(i_arst_n),
        .i_ce(i_ce),
        .i_inc(pw_inc),
        .i_clr(pw_clr),
        .o_count(pw_cnt)
    );

    // ---------------------------------------------------------------
    // count source selection
    // ---------------------------------------------------------------
    always_comb begin
        k = `ITB_TAP_S0;
        tick = 1'b0;
        if (!mode_q.mode_select) begin
            case (mode_q.input_select)
                3'h0: k = `ITB_TAP_S0;
                3'h1: k = `ITB_TAP_S1;
                3'h2: k = `ITB_TAP_S2;
                3'h3: k = `ITB_TAP_S3;
                3'h4: k = `ITB_TAP_S4;
                3'h5: k = `ITB_TAP_S5;
                3'h6: k = `ITB_TAP_S6;
                3'h7: k = `ITB_TAP_S7;
                default: k = `ITB_TAP_S0;
            endcase
            tick = ps_inc && tap_hit(ps_ext, k);
        end else begin
            case (mode_q.input_select[1:0])
                2'h0: k = `ITB_TAP_W0;
                2'h1: k = `ITB_TAP_W1;
                2'h2: k = `ITB_TAP_W2;
                2'h3: k = `ITB_TAP_W3;
                default: k = `ITB_TAP_W0;
            endcase
            tick = pw_inc && !cnt_clr && tap_hit(pw_ext, k);
        end
    end

    // ---------------------------------------------------------------
    // bus handshake
    // ---------------------------------------------------------------
    // one wait cycle: request seen, then answered on the next edge
    assign req = i_avs_read || i_avs_write;
    assign take_wr = i_avs_write && !wait_q;
    assign wr_lane = take_wr && i_avs_byteenable[0];

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        mode_d = mode_q;
        cnt_d = cnt_q;
        ovf_d = ovf_q;
        ien_d = ien_q;
        sub_d = i_subclk;
        clkout_d = 1'b0;
        oe_d = i_pin_out_en;

        // register writes; the count address takes none
        if (wr_lane) begin
            case (i_avs_address)
                `ITB_ADDR_MODE: begin
                    mode_d = itb_mode_type'(i_avs_writedata[7:0]);
                    mode_d.reserved = 1'b0;
                end
                `ITB_ADDR_STATUS: begin
                    if (i_avs_writedata[`ITB_OVF_BIT]) begin
                        ovf_d = 1'b0;
                    end
                end
                `ITB_ADDR_MASK: begin
                    ien_d = i_avs_writedata[`ITB_OVF_BIT];
                end
                default: begin
                end
            endcase
        end

        // counting; an overflow beats a same-cycle flag clear
        if (cnt_clr) begin
            cnt_d = `ITB_CNT_RESET;
        end else if (tick) begin
            cnt_d = 8'(cnt_q + 8'h01);
            if (cnt_q == `ITB_CNT_MAX) begin
                ovf_d = 1'b1;
            end
        end

        irq_d = ovf_d && ien_d;

        // divided clock output
        if (i_pin_out_en) begin
            if (!mode_q.clkout_select[2]) begin
                if (!i_subactive) begin
                    clkout_d = ps_ext[out_bit(mode_q.clkout_select[1:0])];
                end
            end else begin
                clkout_d = pw_ext[out_bit(mode_q.clkout_select[1:0])];
            end
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            mode_q <= itb_mode_type'(`ITB_MODE_RESET);
            cnt_q <= `ITB_CNT_RESET;
            ovf_q <= `ITB_STAT_RESET;
            ien_q <= `ITB_MASK_RESET;
            // a subclock already high at release is not taken as an edge
            sub_q <= 1'b1;
            irq_q <= 1'b0;
            clkout_q <= 1'b0;
            oe_q <= 1'b0;
        end else if (i_ce) begin
            mode_q <= mode_d;
            cnt_q <= cnt_d;
            ovf_q <= ovf_d;
            ien_q <= ien_d;
            sub_q <= sub_d;
            irq_q <= irq_d;
            clkout_q <= clkout_d;
            oe_q <= oe_d;
        end
    end

    // ---------------------------------------------------------------
    // bus answer
    // ---------------------------------------------------------------
    always_comb begin
        wait_d = !(req && wait_q);
        rdata_d = rdata_q;
        // read data sampled on the same edge that drops waitrequest
        if (i_avs_read && wait_q) begin
            rdata_d = 32'h0000_0000;
            case (i_avs_address)
                `ITB_ADDR_MODE: begin
                    rdata_d[7:0] = mode_q;
                    rdata_d[`ITB_MODE_RSVD_BIT] = 1'b1;
                end
                `ITB_ADDR_COUNT: begin
                    if (!i_subactive) begin
                        rdata_d[7:0] = cnt_q;
                    end
                end
                `ITB_ADDR_STATUS: begin
                    rdata_d[`ITB_OVF_BIT] = ovf_q;
                end
                `ITB_ADDR_MASK: begin
                    rdata_d[`ITB_OVF_BIT] = ien_q;
                end
                default: begin
                    rdata_d = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else if (i_ce) begin
            wait_q <= wait_d;
            rdata_q <= rdata_d;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign o_avs_readdata = rdata_q;
    assign o_avs_waitrequest = wait_q;
    assign o_irq = irq_q;
    assign o_clkout = clkout_q;
    assign o_clkout_oe = oe_q;

endmodule : itb_timer

//--- bench/itb_timer_props.sv
`timescale 1ns/1ns
`include "itb_map.svh"
module itb_props
    import itb_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_subactive,
    input wire logic i_pin_out_en,
    input wire logic [4:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic o_irq,
    input wire logic o_clkout,
    input wire logic o_clkout_oe
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_arst_n);
    wire req = i_avs_read || i_avs_write;
    wire take = !o_avs_waitrequest;
    wire rd_mode = i_avs_read && i_avs_address == `ITB_ADDR_MODE;
    wire rd_sub = i_avs_read && i_subactive &&
        i_avs_address == `ITB_ADDR_COUNT;
    wire rd_bad = i_avs_read && (i_avs_address[4] ||
        i_avs_address[1:0] != 2'h0);
    wire mask_off = i_avs_write && take && !i_avs_writedata[0] &&
        i_avs_byteenable[0] && i_avs_address == `ITB_ADDR_MASK;
    ans_next_a: assert property (
        req && o_avs_waitrequest |=> take) else $error("no answer");
    wait_cause_a: assert property (
        take |-> $past(req)) else $error("answer without request");
    rsvd_one_a: assert property (
        take && $past(rd_mode) |-> o_avs_readdata[4]) else $error("bit4");
    bad_read_a: assert property (
        take && $past(rd_bad) |-> o_avs_readdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    sub_read_a: assert property (
        take && $past(rd_sub) |-> o_avs_readdata[7:0] == 8'h00)
        else $error("subactive count read not zero");
    mask_irq_a: assert property (
        mask_off |-> ##2 !o_irq) else $error("irq while masked");
    pin_gate_a: assert property (
        !$past(i_pin_out_en) && !$past(i_pin_out_en, 2) |-> !o_clkout)
        else $error("clock on disabled pin");
    oe_follow_a: assert property (
        $rose(i_pin_out_en) |=> o_clkout_oe) else $error("oe late");
    cover property (o_irq);
    cover property (take && $past(rd_sub));
    cover property ($rose(o_clkout));
endmodule : itb_props
bind itb_timer itb_props u_itb_props (.i_clk_sys, .i_arst_n,
    .i_subactive, .i_pin_out_en, .i_avs_address, .i_avs_read,
    .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata,
    .o_avs_waitrequest, .o_irq, .o_clkout, .o_clkout_oe);

//--- bench/itb_timer_tb.sv
`timescale 1ns/1ns
`include "itb_map.svh"
module itb_timer_tb;
    logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, sclk = 1'b0, srun = 1'b0;
    logic sub = 1'b0, pen = 1'b0, rd = 1'b0, wr = 1'b0;
    logic [4:0] adr = 5'h00;
    logic [31:0] wd = 32'h0000_0000;
    logic [3:0] be = 4'hf;
    logic [31:0] rdat, rv;
    logic [7:0] c0;
    logic wq, irq, co, coe;
    int errors = 0;
    int n_checks = 0;
    int m;
    int per [12] = '{8192, 4096, 2048, 512, 256, 128, 32, 8,
        256, 128, 64, 8};
    logic [4:0] ra [5] = '{`ITB_ADDR_MODE, `ITB_ADDR_COUNT,
        `ITB_ADDR_STATUS, `ITB_ADDR_MASK, 5'h10};
    always #4 clk = ~clk;
    // subclock pulse every second cycle while running
    always @(posedge clk) begin
        if (srun) begin
            sclk <= ~sclk;
        end
    end
    itb_timer u_itb_timer (.i_clk_sys(clk), .i_arst_n(rst_n), .i_ce(ce),
        .i_subclk(sclk), .i_subactive(sub), .i_pin_out_en(pen),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wd), .i_avs_byteenable(be),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wq), .o_irq(irq),
        .o_clkout(co), .o_clkout_oe(coe));
    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude
    task automatic stuck();
        $display("[FAIL] %0t timeout", $time);
        errors++;
        conclude();
    endtask : stuck
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    // request held until the edge that sees waitrequest low
    task automatic bus(input logic w, input logic [4:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wq !== 1'b0 && n < 50);
        if (wq !== 1'b0) stuck();
        rv = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic wait_co(input logic v);
        int n;
        n = 0;
        while (co !== v) begin
            @(negedge clk);
            m++;
            n++;
            if (n > 500) stuck();
        end
    endtask : wait_co
    initial begin
        tick(10);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, ra[i], 32'h0);
            chk(rv, (i == 0) ? 32'h10 : 32'h0);
        end
        $display("reset values done");
        srun <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            bus(1'b1, `ITB_ADDR_MODE, i);
            bus(1'b0, `ITB_ADDR_COUNT, 32'h0);
            c0 = rv[7:0];
            tick(2 * per[i] - 3);
            bus(1'b0, `ITB_ADDR_COUNT, 32'h0);
            chk({24'h0, rv[7:0] - c0}, 32'h2);
        end
        $display("rates done");
        bus(1'b1, `ITB_ADDR_MODE, 32'hef);
        tick(20);
        bus(1'b0, `ITB_ADDR_MODE, 32'h0);
        chk(rv, 32'hff);
        bus(1'b0, `ITB_ADDR_COUNT, 32'h0);
        chk(rv, 32'h0);
        bus(1'b1, `ITB_ADDR_MODE, 32'h08);
        tick(200);
        bus(1'b0, `ITB_ADDR_COUNT, 32'h0);
        chk(rv, 32'h0);
        tick(100);
        bus(1'b0, `ITB_ADDR_COUNT, 32'h0);
        chk(rv, 32'h1);
        srun <= 1'b0;
        sub <= 1'b1;
        bus(1'b0, `ITB_ADDR_COUNT, 32'h0);
        chk(rv, 32'h0);
        sub <= 1'b0;
        bus(1'b1, `ITB_ADDR_COUNT, 32'h55);
        bus(1'b0, `ITB_ADDR_COUNT, 32'h0);
        chk(rv, 32'h1);
        $display("time base done");
        bus(1'b1, `ITB_ADDR_MODE, 32'h07);
        bus(1'b1, `ITB_ADDR_STATUS, 32'h1);
        m = 0;
        do begin
            bus(1'b0, `ITB_ADDR_STATUS, 32'h0);
            m++;
        end while (rv[0] !== 1'b1 && m < 1000);
        if (rv[0] !== 1'b1) stuck();
        bus(1'b0, `ITB_ADDR_COUNT, 32'h0);
        chk({25'h0, rv[7:1]}, 32'h0);
        @(negedge clk);
        chk({31'h0, irq}, 32'h0);
        @(posedge clk);
        bus(1'b1, `ITB_ADDR_MASK, 32'h1);
        @(negedge clk);
        chk({31'h0, irq}, 32'h1);
        @(posedge clk);
        bus(1'b1, `ITB_ADDR_STATUS, 32'h1);
        @(negedge clk);
        chk({31'h0, irq}, 32'h0);
        @(posedge clk);
        bus(1'b1, `ITB_ADDR_MASK, 32'h0);
        $display("overflow done");
        pen <= 1'b1;
        srun <= 1'b1;
        for (int c = 0; c < 8; c++) begin
            sub <= c[2];
            bus(1'b1, `ITB_ADDR_MODE, c << 5);
            // skip the edge where the old source hands over
            @(negedge clk);
            wait_co(1'b0);
            wait_co(1'b1);
            m = 0;
            wait_co(1'b0);
            wait_co(1'b1);
            chk(m, (c < 4 ? 32 : 64) >> (c % 4));
            chk({31'h0, coe}, 32'h1);
            @(posedge clk);
        end
        pen <= 1'b0;
        sub <= 1'b0;
        tick(8);
        @(negedge clk);
        chk({30'h0, co, coe}, 32'h0);
        $display("clock out done");
        @(posedge clk);
        bus(1'b1, `ITB_ADDR_MODE, 32'h07);
        bus(1'b0, `ITB_ADDR_COUNT, 32'h0);
        c0 = rv[7:0];
        ce <= 1'b0;
        tick(200);
        ce <= 1'b1;
        bus(1'b0, `ITB_ADDR_COUNT, 32'h0);
        chk({31'h0, (rv[7:0] - c0) <= 8'h01}, 32'h1);
        $display("clock enable done");
        bus(1'b1, `ITB_ADDR_MASK, 32'h1);
        rst_n <= 1'b0;
        tick(3);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, ra[i], 32'h0);
            chk(rv, (i == 0) ? 32'h10 : 32'h0);
        end
        $display("mid-run reset done");
        conclude();
    end
endmodule : itb_timer_tb
